/* hw/t3rc_top.sv */
`timescale 1ns/100ps
module t3rc_top (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // register write strobe
  input wire logic [7:0] sfr_wdata, // register write data
  output logic [7:0] sfr_rdata, // register read data, one cycle after address
  input wire logic high_byte_clk_sel, // high byte runs on system clock in split mode; the 16-bit count follows low_byte_clk_sel
  input wire logic low_byte_clk_sel, // low byte runs on system clock
  input wire logic ext_osc, // external oscillator pin
  input wire logic sof_event, // frame-start event from the serial bus core
  input wire logic slow_internal_osc, // slow internal oscillator output
  output logic irq_req // interrupt request before the external enable gate
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_sync_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_sync_b = rst_sync_q;

  // ************************************************************
  // input synchronisers and prescalers
  // ************************************************************
  logic ext_rise;
  logic sof_stb;
  logic osc_stb;
  logic tick_div12;
  logic tick_ext8;

  t3rc_edge_sync u_ext_sync (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .async_in(ext_osc),
    .rise_stb(ext_rise)
  );

  t3rc_edge_sync u_sof_sync (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .async_in(sof_event),
    .rise_stb(sof_stb)
  );

  t3rc_edge_sync u_osc_sync (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .async_in(slow_internal_osc),
    .rise_stb(osc_stb)
  );

  t3rc_tick_gen u_tick (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .ext_rise(ext_rise),
    .tick_div12(tick_div12),
    .tick_ext8(tick_ext8)
  );

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] reload_lo_q;
  logic [7:0] reload_lo_d;
  logic [7:0] reload_hi_q;
  logic [7:0] reload_hi_d;
  logic [7:0] count_lo_q;
  logic [7:0] count_lo_d;
  logic [7:0] count_hi_q;
  logic [7:0] count_hi_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;

  logic run;
  logic split;
  logic cap_en;
  logic low_irq_en;
  logic ext_sel;
  logic cap_stb;
  logic capture_now;
  logic lo_tick;
  logic hi_tick;
  logic lo_wrap;
  logic hi_wrap;
  logic [15:0] count16;
  logic wr_ctrl;
  logic wr_rl;
  logic wr_rh;
  logic wr_cl;
  logic wr_ch;

  always_comb begin
    run = ctrl_q[t3rc_pkg::BIT_RUN];
    split = ctrl_q[t3rc_pkg::BIT_SPLIT];
    cap_en = ctrl_q[t3rc_pkg::BIT_CAPTURE_EN];
    low_irq_en = ctrl_q[t3rc_pkg::BIT_LOW_IRQ_EN];
    ext_sel = ctrl_q[t3rc_pkg::BIT_EXT_CLK_SEL];
    count16 = {count_hi_q, count_lo_q};
    wr_ctrl = sfr_wr && (sfr_addr == t3rc_pkg::ADDR_CONTROL);
    wr_rl = sfr_wr && (sfr_addr == t3rc_pkg::ADDR_RELOAD_LO);
    wr_rh = sfr_wr && (sfr_addr == t3rc_pkg::ADDR_RELOAD_HI);
    wr_cl = sfr_wr && (sfr_addr == t3rc_pkg::ADDR_COUNT_LO);
    wr_ch = sfr_wr && (sfr_addr == t3rc_pkg::ADDR_COUNT_HI);
    // capture source: 0 frame start, 1 slow oscillator rising edge
    cap_stb = ctrl_q[t3rc_pkg::BIT_CAPTURE_SRC] ? osc_stb : sof_stb;
    capture_now = cap_en && cap_stb;
    // 16-bit modes count on the low byte's clock choice
    lo_tick = t3rc_pkg::pick_tick(low_byte_clk_sel, ext_sel, tick_div12, tick_ext8);
    hi_tick = t3rc_pkg::pick_tick(high_byte_clk_sel, ext_sel, tick_div12, tick_ext8);
  end

  // ************************************************************
  // counter, reload and control next state
  // ************************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    reload_lo_d = reload_lo_q;
    reload_hi_d = reload_hi_q;
    count_lo_d = count_lo_q;
    count_hi_d = count_hi_q;
    lo_wrap = 1'b0;
    hi_wrap = 1'b0;
    if (!split) begin
      if (run && lo_tick) begin
        lo_wrap = t3rc_pkg::byte_wraps(count_lo_q);
        if (count16 == t3rc_pkg::WORD_MAX) begin
          hi_wrap = 1'b1;
          // capture mode wraps to zero, reload mode takes the reload pair
          {count_hi_d, count_lo_d} = cap_en ? t3rc_pkg::WORD_ZERO
                                            : {reload_hi_q, reload_lo_q};
        end else begin
          {count_hi_d, count_lo_d} = 16'(count16 + 16'h0001);
        end
      end
    end else begin
      if (lo_tick) begin
        lo_wrap = t3rc_pkg::byte_wraps(count_lo_q);
        if (lo_wrap) begin
          count_lo_d = cap_en ? t3rc_pkg::BYTE_RESET : reload_lo_q;
        end else begin
          count_lo_d = 8'(count_lo_q + 8'h01);
        end
      end
      if (run && hi_tick) begin
        hi_wrap = t3rc_pkg::byte_wraps(count_hi_q);
        if (hi_wrap) begin
          count_hi_d = cap_en ? t3rc_pkg::BYTE_RESET : reload_hi_q;
        end else begin
          count_hi_d = 8'(count_hi_q + 8'h01);
        end
      end
    end
    // a software write to a count byte takes precedence over counting
    if (wr_cl) begin
      count_lo_d = sfr_wdata;
    end
    if (wr_ch) begin
      count_hi_d = sfr_wdata;
    end
    if (wr_rl) begin
      reload_lo_d = sfr_wdata;
    end
    if (wr_rh) begin
      reload_hi_d = sfr_wdata;
    end
    // a capture beats a software write so no event is lost
    if (capture_now) begin
      reload_lo_d = count_lo_q;
      reload_hi_d = count_hi_q;
    end
    if (wr_ctrl) begin
      ctrl_d = sfr_wdata;
    end
    // hardware only ever sets the flags, and a set beats a same-cycle clear
    if (hi_wrap || capture_now) begin
      ctrl_d[t3rc_pkg::BIT_HIGH_FLAG] = 1'b1;
    end
    if (lo_wrap) begin
      ctrl_d[t3rc_pkg::BIT_LOW_FLAG] = 1'b1;
    end
  end

  // ************************************************************
  // interrupt request and read data
  // ************************************************************
  always_comb begin
    irq_d = ctrl_q[t3rc_pkg::BIT_HIGH_FLAG]
            | (ctrl_q[t3rc_pkg::BIT_LOW_FLAG] & low_irq_en);
    case (sfr_addr)
      t3rc_pkg::ADDR_CONTROL: rdata_d = ctrl_q;
      t3rc_pkg::ADDR_RELOAD_LO: rdata_d = reload_lo_q;
      t3rc_pkg::ADDR_RELOAD_HI: rdata_d = reload_hi_q;
      t3rc_pkg::ADDR_COUNT_LO: rdata_d = count_lo_q;
      t3rc_pkg::ADDR_COUNT_HI: rdata_d = count_hi_q;
      default: rdata_d = t3rc_pkg::BYTE_RESET;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_q <= t3rc_pkg::CONTROL_RESET;
      reload_lo_q <= t3rc_pkg::BYTE_RESET;
      reload_hi_q <= t3rc_pkg::BYTE_RESET;
      count_lo_q <= t3rc_pkg::BYTE_RESET;
      count_hi_q <= t3rc_pkg::BYTE_RESET;
      rdata_q <= t3rc_pkg::BYTE_RESET;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      reload_lo_q <= reload_lo_d;
      reload_hi_q <= reload_hi_d;
      count_lo_q <= count_lo_d;
      count_hi_q <= count_hi_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign irq_req = irq_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_reload16;
    @(posedge mclk) disable iff (!rst_sync_b)
    (!split && !cap_en && run && lo_tick && count16 == t3rc_pkg::WORD_MAX
     && !wr_cl && !wr_ch)
    |=> ({count_hi_q, count_lo_q} == $past({reload_hi_q, reload_lo_q}));
  endproperty
  a_reload16: assert property (p_reload16)
    else $error("16-bit overflow did not load the reload pair");

  property p_high_flag_set;
    @(posedge mclk) disable iff (!rst_sync_b)
    (!split && run && lo_tick && count16 == t3rc_pkg::WORD_MAX)
    |=> ctrl_q[t3rc_pkg::BIT_HIGH_FLAG] && ctrl_q[t3rc_pkg::BIT_LOW_FLAG];
  endproperty
  a_high_flag_set: assert property (p_high_flag_set)
    else $error("16-bit overflow did not set both flags");

  property p_low_flag_any_mode;
    @(posedge mclk) disable iff (!rst_sync_b)
    ((split || run) && lo_tick && count_lo_q == t3rc_pkg::BYTE_MAX)
    |=> ctrl_q[t3rc_pkg::BIT_LOW_FLAG];
  endproperty
  a_low_flag_any_mode: assert property (p_low_flag_any_mode)
    else $error("low byte wrap did not set the low flag");

  property p_flags_sticky;
    @(posedge mclk) disable iff (!rst_sync_b)
    (ctrl_q[t3rc_pkg::BIT_HIGH_FLAG] && !wr_ctrl) |=> ctrl_q[t3rc_pkg::BIT_HIGH_FLAG];
  endproperty
  a_flags_sticky: assert property (p_flags_sticky)
    else $error("high flag dropped without a software write");

  property p_irq_follows_flags;
    @(posedge mclk) disable iff (!rst_sync_b)
    (ctrl_q[t3rc_pkg::BIT_LOW_FLAG] && low_irq_en) ##1 ctrl_q[t3rc_pkg::BIT_LOW_FLAG]
    |-> irq_req;
  endproperty
  a_irq_follows_flags: assert property (p_irq_follows_flags)
    else $error("enabled low flag did not raise the request");

  property p_split_low_free;
    @(posedge mclk) disable iff (!rst_sync_b)
    (split && !run && lo_tick && !wr_cl && !wr_ch && count_lo_q != t3rc_pkg::BYTE_MAX)
    |=> (count_lo_q == 8'($past(count_lo_q) + 8'h01)) && $stable(count_hi_q);
  endproperty
  a_split_low_free: assert property (p_split_low_free)
    else $error("split low byte did not count with run clear");

  property p_run_stops;
    @(posedge mclk) disable iff (!rst_sync_b)
    (!split && !run && !wr_cl && !wr_ch) |=> $stable(count_lo_q) && $stable(count_hi_q);
  endproperty
  a_run_stops: assert property (p_run_stops)
    else $error("16-bit counter moved with run clear");

  property p_capture_latch;
    @(posedge mclk) disable iff (!rst_sync_b)
    capture_now |=> ({reload_hi_q, reload_lo_q} == $past(count16))
                    && ctrl_q[t3rc_pkg::BIT_HIGH_FLAG];
  endproperty
  a_capture_latch: assert property (p_capture_latch)
    else $error("capture did not latch the count");

  property p_split_high_reload;
    @(posedge mclk) disable iff (!rst_sync_b)
    (split && !cap_en && run && hi_tick && count_hi_q == t3rc_pkg::BYTE_MAX && !wr_ch)
    |=> (count_hi_q == $past(reload_hi_q));
  endproperty
  a_split_high_reload: assert property (p_split_high_reload)
    else $error("split high byte wrap did not take its reload byte");

  property p_irq_quiet;
    @(posedge mclk) disable iff (!rst_sync_b)
    (!ctrl_q[t3rc_pkg::BIT_HIGH_FLAG] && !(ctrl_q[t3rc_pkg::BIT_LOW_FLAG] && low_irq_en))
    |=> !irq_req;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("request raised with no enabled flag set");

  property p_read_control;
    @(posedge mclk) disable iff (!rst_sync_b)
    (sfr_addr == t3rc_pkg::ADDR_CONTROL) |=> (sfr_rdata == $past(ctrl_q));
  endproperty
  a_read_control: assert property (p_read_control)
    else $error("control read did not return the control byte");

endmodule : t3rc_top

/* hw/t3rc_pkg.sv */
package t3rc_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h95;

  // ************************************************************
  // control register fields and reset values
  // ************************************************************
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CAPTURE_SRC = 1;
  localparam int BIT_EXT_CLK_SEL = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] WORD_MAX = 16'hffff;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ************************************************************
  // prescaler counts
  // ************************************************************
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic byte_wraps(input logic [7:0] value);
    byte_wraps = (value == BYTE_MAX);
  endfunction : byte_wraps

  function automatic logic pick_tick(input logic sys_sel, input logic ext_sel,
                                     input logic tick_div12, input logic tick_ext8);
    pick_tick = sys_sel ? 1'b1 : (ext_sel ? tick_ext8 : tick_div12);
  endfunction : pick_tick

endpackage : t3rc_pkg

/* hw/t3rc_edge_sync.sv */
`timescale 1ns/100ps
module t3rc_edge_sync (
  input wire logic mclk, // system clock
  input wire logic rst_sync_b, // synchronised reset, active low
  input wire logic async_in, // level from outside this clock domain
  output logic rise_stb // one-cycle strobe per rising edge
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic rise_q;
  logic rise_d;

  // ************************************************************
  // two-flop synchroniser, then edge detect on the clean copy
  // ************************************************************
  always_comb begin
    rise_d = sync_q & ~prev_q;
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      rise_q <= rise_d;
    end
  end

  assign rise_stb = rise_q;

  property p_single_strobe;
    @(posedge mclk) disable iff (!rst_sync_b)
    rise_stb |=> !rise_stb;
  endproperty
  a_single_strobe: assert property (p_single_strobe)
    else $error("edge strobe lasted more than one cycle");

endmodule : t3rc_edge_sync

/* hw/t3rc_tick_gen.sv */
`timescale 1ns/100ps
module t3rc_tick_gen (
  input wire logic mclk, // system clock
  input wire logic rst_sync_b, // synchronised reset, active low
  input wire logic ext_rise, // synchronised rising edge of external oscillator
  output logic tick_div12, // one pulse every twelve system clocks
  output logic tick_ext8 // one pulse every eight external edges
);

  logic [3:0] div12_q;
  logic [3:0] div12_d;
  logic [2:0] ext8_q;
  logic [2:0] ext8_d;
  logic t12_q;
  logic t12_d;
  logic t8_q;
  logic t8_d;

  // ************************************************************
  // prescalers
  // ************************************************************
  // the external source is counted in edges after synchronisation, so it
  // must run below half the system clock to be counted faithfully
  always_comb begin
    t12_d = (div12_q == t3rc_pkg::SYS_DIV_LAST);
    div12_d = t12_d ? 4'h0 : 4'(div12_q + 4'h1);
    t8_d = ext_rise && (ext8_q == t3rc_pkg::EXT_DIV_LAST);
    ext8_d = ext_rise ? 3'(ext8_q + 3'h1) : ext8_q;
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      div12_q <= 4'h0;
      ext8_q <= 3'h0;
      t12_q <= 1'b0;
      t8_q <= 1'b0;
    end else begin
      div12_q <= div12_d;
      ext8_q <= ext8_d;
      t12_q <= t12_d;
      t8_q <= t8_d;
    end
  end

  assign tick_div12 = t12_q;
  assign tick_ext8 = t8_q;

  property p_div12_spacing;
    @(posedge mclk) disable iff (!rst_sync_b)
    tick_div12 |=> !tick_div12 [*8];
  endproperty
  a_div12_spacing: assert property (p_div12_spacing)
    else $error("divide-by-12 tick came too early");

endmodule : t3rc_tick_gen

/* bench/tb_t3rc_top.sv */
`timescale 1ns/100ps
module tb_t3rc_top;
  logic mclk;
  logic rst_b;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic high_byte_clk_sel;
  logic low_byte_clk_sel;
  logic ext_osc = 1'b0;
  logic [1:0] ext_div = 2'h0;
  logic sof_event;
  logic slow_internal_osc;
  logic irq_req;
  int fails = 0;
  int checked = 0;
  int cyc = 0;

  t3rc_top dut (
    .mclk(mclk),
    .rst_b(rst_b),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .high_byte_clk_sel(high_byte_clk_sel),
    .low_byte_clk_sel(low_byte_clk_sel),
    .ext_osc(ext_osc),
    .sof_event(sof_event),
    .slow_internal_osc(slow_internal_osc),
    .irq_req(irq_req)
  );

  // ************************************************************
  // clock, external oscillator (rising edge every 4 clocks), cycle count
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    ext_div <= ext_div + 2'h1;
    cyc <= cyc + 1;
    if (ext_div[0]) begin
      ext_osc <= ~ext_osc;
    end
  end

  // ************************************************************
  // bus tasks and compares
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask : wr

  // read data is registered: valid just after the edge that samples the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr_addr <= a;
    @(posedge mclk);
    #1;
    d = sfr_rdata;
  endtask : rd

  task automatic rd16(input logic [7:0] a, output logic [15:0] w);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    w = {hi, lo};
  endtask : rd16

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  task automatic pulse(input logic slow);
    @(posedge mclk);
    if (slow) slow_internal_osc <= 1'b1;
    else sof_event <= 1'b1;
    idle(6);
    slow_internal_osc <= 1'b0;
    sof_event <= 1'b0;
    idle(6);
  endtask : pulse

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_byte

  task automatic check_range(input string what, input logic [15:0] lo, input logic [15:0] hi,
                             input logic [15:0] seen);
    checked++;
    if ($isunknown(seen) || seen < lo || seen > hi) begin
      fails++;
      $display("mismatch %s expected %h..%h seen %h", what, lo, hi, seen);
    end
  endtask : check_range

  task automatic check_irq(input logic exp);
    #1;
    checked++;
    if (irq_req !== exp) begin
      fails++;
      $display("mismatch irq_req expected %b seen %b", exp, irq_req);
    end
  endtask : check_irq

  // control byte from its fields, bit 7 down to bit 0
  function automatic logic [7:0] ctl(input logic h, l, len, ce, sp, run, css, xc);
    ctl = {h, l, len, ce, sp, run, css, xc};
  endfunction : ctl

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    #500000;
    fails++;
    summarize();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    logic [7:0] v;
    logic [7:0] rl;
    logic [7:0] rh;
    logic [15:0] w;
    logic [15:0] w2;
    logic sp;
    logic css;
    logic xc;
    int t0;
    int d;
    rst_b = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    high_byte_clk_sel = 1'b1;
    low_byte_clk_sel = 1'b1;
    sof_event = 1'b0;
    slow_internal_osc = 1'b0;
    void'($urandom(32'h9884_9a23));
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    idle(3);
    for (int i = 0; i < 6; i++) begin
      rd(t3rc_pkg::ADDR_CONTROL + 8'(i), v);
      check_byte("reset value", t3rc_pkg::BYTE_RESET, v);
    end
    check_irq(1'b0);
    for (int i = 1; i < 5; i++) begin
      rl = 8'($urandom);
      wr(t3rc_pkg::ADDR_CONTROL + 8'(i), rl);
      rd(t3rc_pkg::ADDR_CONTROL + 8'(i), v);
      check_byte("byte readback", rl, v);
    end
    wr(8'h96, 8'hff);
    rd(t3rc_pkg::ADDR_CONTROL, v);
    check_byte("unmapped write", 8'h00, v);
    $display("test registers done");

    rl = 8'($urandom);
    rh = 8'($urandom_range(0, 254));
    wr(t3rc_pkg::ADDR_RELOAD_LO, rl);
    wr(t3rc_pkg::ADDR_RELOAD_HI, rh);
    wr(t3rc_pkg::ADDR_COUNT_LO, 8'hf0);
    wr(t3rc_pkg::ADDR_COUNT_HI, 8'hff);
    wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, 0, 1, 0, 0));
    idle(40);
    rd(t3rc_pkg::ADDR_CONTROL, v);
    check_byte("control after wrap", ctl(1, 1, 0, 0, 0, 1, 0, 0), v);
    check_irq(1'b1);
    wr(t3rc_pkg::ADDR_CONTROL, 8'h00);
    idle(3);
    check_irq(1'b0);
    rd16(t3rc_pkg::ADDR_COUNT_LO, w);
    check_range("count after reload", {rh, rl} + 16'h0014, {rh, rl} + 16'h0028, w);
    idle(10);
    rd16(t3rc_pkg::ADDR_COUNT_LO, w2);
    check_range("stopped count", w, w, w2);
    for (int en = 0; en < 2; en++) begin
      wr(t3rc_pkg::ADDR_COUNT_LO, 8'hf8);
      wr(t3rc_pkg::ADDR_COUNT_HI, 8'h30);
      wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 1'(en), 0, 0, 1, 0, 0));
      idle(20);
      rd(t3rc_pkg::ADDR_CONTROL, v);
      check_byte("low wrap flag", ctl(0, 1, 1'(en), 0, 0, 1, 0, 0), v);
      check_irq(1'(en));
      wr(t3rc_pkg::ADDR_CONTROL, 8'h00);
      rd(t3rc_pkg::ADDR_COUNT_HI, v);
      check_byte("carry into high", 8'h31, v);
    end
    $display("test sixteen bit done");

    rl = 8'($urandom_range(0, 64));
    rh = 8'($urandom_range(0, 64));
    wr(t3rc_pkg::ADDR_RELOAD_LO, rl);
    wr(t3rc_pkg::ADDR_RELOAD_HI, rh);
    wr(t3rc_pkg::ADDR_COUNT_HI, 8'h50);
    wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, 1, 0, 0, 0));
    wr(t3rc_pkg::ADDR_COUNT_LO, 8'hf0);
    idle(40);
    rd(t3rc_pkg::ADDR_CONTROL, v);
    check_byte("split low flag", ctl(0, 1, 0, 0, 1, 0, 0, 0), v);
    check_irq(1'b0);
    rd(t3rc_pkg::ADDR_COUNT_HI, v);
    check_byte("high held", 8'h50, v);
    rd(t3rc_pkg::ADDR_COUNT_LO, v);
    check_range("low reload", {8'h00, rl} + 16'h0014, {8'h00, rl} + 16'h002d, {8'h00, v});
    wr(t3rc_pkg::ADDR_COUNT_HI, 8'hf8);
    wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 1, 0, 1, 1, 0, 0));
    idle(30);
    rd(t3rc_pkg::ADDR_CONTROL, v);
    check_byte("split high flag", ctl(1, 0, 1, 0, 1, 1, 0, 0), v);
    check_irq(1'b1);
    rd(t3rc_pkg::ADDR_COUNT_HI, v);
    check_range("high reload", {8'h00, rh} + 16'h000f, {8'h00, rh} + 16'h0023, {8'h00, v});
    wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 1, 0, 1, 0, 0, 0));
    idle(200);
    rd(t3rc_pkg::ADDR_CONTROL, v);
    check_byte("split low irq", ctl(0, 1, 1, 0, 1, 0, 0, 0), v);
    check_irq(1'b1);
    $display("test split done");

    // window of 120 or 320 clocks is ten ticks of either prescaler
    high_byte_clk_sel <= 1'b0;
    for (int x = 0; x < 4; x++) begin
      sp = 1'(x < 2);
      xc = 1'(x % 2);
      low_byte_clk_sel <= sp;
      wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, sp, 0, 0, xc));
      wr(t3rc_pkg::ADDR_COUNT_HI, 8'h00);
      wr(t3rc_pkg::ADDR_COUNT_LO, 8'h00);
      wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, sp, 1, 0, xc));
      idle(xc ? 318 : 118);
      wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 0, 0, sp, 0, 0, xc));
      rd(sp ? t3rc_pkg::ADDR_COUNT_HI : t3rc_pkg::ADDR_COUNT_LO, v);
      check_range("prescaled ticks", 16'h0009, 16'h000b, {8'h00, v});
    end
    high_byte_clk_sel <= 1'b1;
    low_byte_clk_sel <= 1'b1;
    $display("test clock select done");

    for (int m = 0; m < 4; m++) begin
      sp = 1'(m >> 1);
      css = 1'(m);
      rl = 8'($urandom);
      rh = 8'($urandom);
      wr(t3rc_pkg::ADDR_CONTROL, 8'h00);
      wr(t3rc_pkg::ADDR_RELOAD_LO, rl);
      wr(t3rc_pkg::ADDR_RELOAD_HI, rh);
      wr(t3rc_pkg::ADDR_COUNT_LO, 8'h10);
      wr(t3rc_pkg::ADDR_COUNT_HI, 8'h20);
      wr(t3rc_pkg::ADDR_CONTROL, ctl(0, 0, 0, 1, sp, 1, css, 0));
      t0 = cyc;
      pulse(~css);
      rd(t3rc_pkg::ADDR_RELOAD_LO, v);
      check_byte("reload kept", rl, v);
      d = cyc - t0;
      pulse(css);
      rd(t3rc_pkg::ADDR_RELOAD_LO, v);
      check_range("captured low", 16'h0010 + 16'(d), 16'h0018 + 16'(d), {8'h00, v});
      rd(t3rc_pkg::ADDR_RELOAD_HI, v);
      check_range("captured high", sp ? 16'h0020 + 16'(d) : 16'h0020,
                  sp ? 16'h0028 + 16'(d) : 16'h0020, {8'h00, v});
      rd(t3rc_pkg::ADDR_CONTROL, v);
      check_byte("capture flag", ctl(1, 0, 0, 1, sp, 1, css, 0), v);
      check_irq(1'b1);
      idle(50);
      rd(t3rc_pkg::ADDR_CONTROL, v);
      check_byte("flag kept", ctl(1, 0, 0, 1, sp, 1, css, 0), v);
    end
    $display("test capture done");
    summarize();
  end
endmodule : tb_t3rc_top
